// ---- hw/bms_pkg.sv ----
// Constants, types and register map of the bridge measurement sequencer
package bms_pkg;
    localparam int unsigned CLK_FREQ_HZ = 10_000_000;
    localparam int unsigned HZ_PER_MHZ = 1_000_000;
    localparam int unsigned CLK_PER_US = CLK_FREQ_HZ / HZ_PER_MHZ;

    // Register byte addresses
    localparam logic [7:0] ADDR_CYCLE_CFG = 8'h00;
    localparam logic [7:0] ADDR_CONV_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0c;
    localparam logic [7:0] ADDR_CONV_INFO = 8'h10;

    // Cycle configuration word fields
    localparam int CYC_T2E_BIT = 0;
    localparam int CYC_T1E_BIT = 1;
    localparam int CYC_T1SRC_LO = 2;
    localparam int CYC_T2SRC_LO = 4;
    localparam int CYC_RUN_BIT = 6;
    localparam int CYC_NCODE_LO = 7;
    localparam int CYC_NCODE_HI = 9;
    localparam logic [31:0] CYC_WMASK = 32'h0000_03ff;
    localparam logic [31:0] CYC_RESET = 32'h0000_0042;

    // Application / converter configuration word fields
    localparam int CNV_ORDER_BIT = 0;
    localparam int CNV_RES_LO = 1;
    localparam int CNV_RES_HI = 4;
    localparam int CNV_RS_LO = 5;
    localparam int CNV_REF_BIT = 7;
    localparam int CNV_XZCE_BIT = 8;
    localparam int CNV_XZC_LO = 9;
    localparam int CNV_XZC_HI = 14;
    localparam logic [31:0] CNV_WMASK = 32'h0000_7fff;
    localparam logic [31:0] CNV_RESET = 32'h0000_0018;

    // Converter limits
    localparam logic [3:0] RES1_MIN = 4'h9;
    localparam logic [3:0] RES1_MAX = 4'he;
    localparam logic [3:0] RES2_MIN = 4'hb;
    localparam logic [3:0] RES2_MAX = 4'hf;
    localparam logic [3:0] RES_OUT_ANALOG_MAX = 4'hb;
    localparam logic [3:0] RES_OUT_PWM_MAX = 4'hc;
    localparam logic [3:0] ORDER2_EXP_ADD = 4'h3;
    // sqrt(2) as 181/128 for half-integer exponents
    localparam int unsigned SQRT2_NUM = 181;
    localparam int SQRT2_SHIFT = 7;
    localparam logic signed [5:0] XZC_GUAR_MAX = 6'sh14;
    localparam logic signed [5:0] XZC_GUAR_MIN = -6'sh14;
    localparam logic signed [5:0] XZC_ACC_MIN = -6'sh1f;
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        MUX_AUTOZERO,
        MUX_DIODE,
        MUX_BRIDGE_RES,
        MUX_THERMISTOR,
        MUX_BRIDGE,
        MUX_COMMON_MODE
    } bms_mux_e;

    typedef enum logic [2:0] {
        TAG_BRIDGE,
        TAG_BRIDGE_AZ,
        TAG_TEMP1_AZ,
        TAG_TEMP1,
        TAG_TEMP2_AZ,
        TAG_TEMP2,
        TAG_COMMON_MODE
    } bms_tag_e;

    typedef struct packed {
        logic [15:0] count;
        bms_tag_e tag;
    } bms_result_s;

    typedef struct packed {
        logic second_order;
        logic [3:0] resolution;
        logic [1:0] range_shift_fraction;
        logic converter_reference_select;
        logic xzc_enable;
        logic signed [5:0] xzc_step;
    } bms_conv_s;
endpackage : bms_pkg

// ---- hw/bms_sequencer.sv ----
// Bridge measurement sequencer with converter control and APB registers
`timescale 1ns/1ns
module bms_sequencer #(
    parameter int unsigned CLK_PER_US = bms_pkg::CLK_PER_US
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [15:0] i_conv_count,
    input wire logic i_res_ready,
    output bms_pkg::bms_mux_e o_mux_sel,
    output logic o_conv_active,
    output bms_pkg::bms_conv_s o_conv_cfg,
    output logic [15:0] o_zero_count,
    output logic o_res_valid,
    output bms_pkg::bms_result_s o_result
);
    typedef enum logic [1:0] {
        ST_PICK,
        ST_CONV,
        ST_HAND
    } bms_state_e;

    logic [31:0] cyc_r;
    logic [31:0] cnv_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    bms_state_e state_r;
    logic in_start_r;
    logic [1:0] start_step_r;
    logic [2:0] phase_r;
    logic [7:0] br_cnt_r;
    logic [bms_pkg::CNT_W-1:0] conv_cnt_r;
    bms_pkg::bms_mux_e mux_r;
    bms_pkg::bms_tag_e tag_r;
    logic res_valid_r;
    bms_pkg::bms_result_s result_r;
    logic [15:0] last_count_r;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [7:0] n_count;
    logic t2e;
    logic t1e;
    logic run;
    logic [3:0] res_eff;
    logic res_bad;
    logic xzc_unguar;
    logic [bms_pkg::CNT_W-1:0] conv_cycles;
    bms_pkg::bms_conv_s conv_cfg;
    bms_pkg::bms_mux_e pick_mux;
    bms_pkg::bms_tag_e pick_tag;
    logic pick_bridge;

    function automatic logic [7:0] ncode_to_count(input logic [2:0] code);
        ncode_to_count = 8'h01 << code;
    endfunction : ncode_to_count

    function automatic bms_pkg::bms_mux_e temp_src(input logic [1:0] sel);
        unique case (sel)
            2'h1: temp_src = bms_pkg::MUX_BRIDGE_RES;
            2'h2: temp_src = bms_pkg::MUX_THERMISTOR;
            default: temp_src = bms_pkg::MUX_DIODE;
        endcase
    endfunction : temp_src

    // Zero-input count: 2^r * (1 - fraction) = 2^r >> (code + 1)
    function automatic logic [15:0] zero_count(input logic [3:0] r,
                                               input logic [1:0] rs);
        logic [16:0] full;
        full = 17'h00001 << r;
        zero_count = full[16:1] >> rs;
    endfunction : zero_count

    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable;
    assign addr_ok = (i_paddr == bms_pkg::ADDR_CYCLE_CFG) ||
                     (i_paddr == bms_pkg::ADDR_CONV_CFG) ||
                     (i_paddr == bms_pkg::ADDR_STATUS) ||
                     (i_paddr == bms_pkg::ADDR_RESULT) ||
                     (i_paddr == bms_pkg::ADDR_CONV_INFO);

    assign n_count = ncode_to_count(
        cyc_r[bms_pkg::CYC_NCODE_HI:bms_pkg::CYC_NCODE_LO]);
    assign t2e = cyc_r[bms_pkg::CYC_T2E_BIT];
    assign t1e = cyc_r[bms_pkg::CYC_T1E_BIT];
    assign run = cyc_r[bms_pkg::CYC_RUN_BIT];

    // Resolution clamped into the legal range of the chosen order
    always_comb
    begin
        logic [3:0] r;
        r = cnv_r[bms_pkg::CNV_RES_HI:bms_pkg::CNV_RES_LO];
        res_eff = r;
        res_bad = 1'b0;
        if (cnv_r[bms_pkg::CNV_ORDER_BIT])
        begin
            if (r < bms_pkg::RES2_MIN)
            begin
                res_eff = bms_pkg::RES2_MIN;
                res_bad = 1'b1;
            end
        end
        else if (r < bms_pkg::RES1_MIN)
        begin
            res_eff = bms_pkg::RES1_MIN;
            res_bad = 1'b1;
        end
        else if (r > bms_pkg::RES1_MAX)
        begin
            res_eff = bms_pkg::RES1_MAX;
            res_bad = 1'b1;
        end
    end

    // Conversion time in clock cycles
    always_comb
    begin
        logic [4:0] e2;
        logic [bms_pkg::CNT_W-1:0] us;
        logic [bms_pkg::CNT_W+7:0] scaled;
        e2 = {1'b0, res_eff} + {1'b0, bms_pkg::ORDER2_EXP_ADD};
        us = '0;
        scaled = '0;
        if (cnv_r[bms_pkg::CNV_ORDER_BIT])
        begin
            us = bms_pkg::CNT_W'(1) << e2[4:1];
            if (!e2[0])
            begin
                us = us;
            end
            else
            begin
                scaled = (bms_pkg::CNT_W+8)'(us) * (bms_pkg::CNT_W+8)'(
                    bms_pkg::SQRT2_NUM);
                us = bms_pkg::CNT_W'(scaled >> bms_pkg::SQRT2_SHIFT);
            end
        end
        else
        begin
            us = bms_pkg::CNT_W'(1) << res_eff;
        end
        scaled = (bms_pkg::CNT_W+8)'(us) * (bms_pkg::CNT_W+8)'(CLK_PER_US);
        conv_cycles = bms_pkg::CNT_W'(scaled);
    end

    // Converter settings driven to the analog path
    always_comb
    begin
        conv_cfg.second_order = cnv_r[bms_pkg::CNV_ORDER_BIT];
        conv_cfg.resolution = res_eff;
        conv_cfg.range_shift_fraction =
            cnv_r[bms_pkg::CNV_RS_LO+1:bms_pkg::CNV_RS_LO];
        conv_cfg.converter_reference_select = cnv_r[bms_pkg::CNV_REF_BIT];
        conv_cfg.xzc_enable = cnv_r[bms_pkg::CNV_XZCE_BIT];
        conv_cfg.xzc_step =
            cnv_r[bms_pkg::CNV_XZC_HI:bms_pkg::CNV_XZC_LO];
        // Minus 32 is outside the accepted span
        if (conv_cfg.xzc_step < bms_pkg::XZC_ACC_MIN)
        begin
            conv_cfg.xzc_step = bms_pkg::XZC_ACC_MIN;
        end
        if (conv_cfg.converter_reference_select)
        begin
            conv_cfg.xzc_enable = 1'b1;
            conv_cfg.xzc_step = '0;
        end
    end

    assign xzc_unguar = (conv_cfg.xzc_step > bms_pkg::XZC_GUAR_MAX) ||
                        (conv_cfg.xzc_step < bms_pkg::XZC_GUAR_MIN);

    // Choice of the next conversion
    always_comb
    begin
        pick_mux = bms_pkg::MUX_BRIDGE;
        pick_tag = bms_pkg::TAG_BRIDGE;
        pick_bridge = 1'b0;
        if (in_start_r)
        begin
            unique case (start_step_r)
                2'h0:
                begin
                    pick_mux = bms_pkg::MUX_BRIDGE;
                    pick_tag = bms_pkg::TAG_BRIDGE;
                end
                2'h1:
                begin
                    pick_mux = bms_pkg::MUX_AUTOZERO;
                    pick_tag = bms_pkg::TAG_BRIDGE_AZ;
                end
                2'h2:
                begin
                    pick_mux = bms_pkg::MUX_AUTOZERO;
                    pick_tag = bms_pkg::TAG_TEMP1_AZ;
                end
                2'h3:
                begin
                    pick_mux = temp_src(cyc_r[bms_pkg::CYC_T1SRC_LO+1:
                                              bms_pkg::CYC_T1SRC_LO]);
                    pick_tag = bms_pkg::TAG_TEMP1;
                end
            endcase
        end
        else if (br_cnt_r < n_count)
        begin
            pick_bridge = 1'b1;
        end
        else
        begin
            unique case (phase_r)
                3'h0:
                begin
                    pick_mux = bms_pkg::MUX_AUTOZERO;
                    pick_tag = bms_pkg::TAG_TEMP1_AZ;
                end
                3'h1:
                begin
                    pick_mux = temp_src(cyc_r[bms_pkg::CYC_T1SRC_LO+1:
                                              bms_pkg::CYC_T1SRC_LO]);
                    pick_tag = bms_pkg::TAG_TEMP1;
                end
                3'h2:
                begin
                    pick_mux = bms_pkg::MUX_AUTOZERO;
                    pick_tag = bms_pkg::TAG_BRIDGE_AZ;
                end
                3'h3:
                begin
                    pick_mux = bms_pkg::MUX_AUTOZERO;
                    pick_tag = bms_pkg::TAG_TEMP2_AZ;
                end
                3'h4:
                begin
                    pick_mux = temp_src(cyc_r[bms_pkg::CYC_T2SRC_LO+1:
                                              bms_pkg::CYC_T2SRC_LO]);
                    pick_tag = bms_pkg::TAG_TEMP2;
                end
                default:
                begin
                    pick_mux = bms_pkg::MUX_COMMON_MODE;
                    pick_tag = bms_pkg::TAG_COMMON_MODE;
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            cyc_r <= bms_pkg::CYC_RESET;
            cnv_r <= bms_pkg::CNV_RESET;
        end
        else if (wr_en && i_paddr == bms_pkg::ADDR_CYCLE_CFG)
        begin
            cyc_r <= i_pwdata & bms_pkg::CYC_WMASK;
        end
        else if (wr_en && i_paddr == bms_pkg::ADDR_CONV_CFG)
        begin
            cnv_r <= i_pwdata & bms_pkg::CNV_WMASK;
        end
    end

    // Read data and error captured in the setup phase
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
        else if (rd_setup)
        begin
            pslverr_r <= !addr_ok;
            prdata_r <= '0;
            if (!i_pwrite)
            begin
                unique case (i_paddr)
                    bms_pkg::ADDR_CYCLE_CFG: prdata_r <= cyc_r;
                    bms_pkg::ADDR_CONV_CFG: prdata_r <= cnv_r;
                    bms_pkg::ADDR_STATUS:
                        prdata_r <= {20'h00000, xzc_unguar, res_bad,
                                     in_start_r, res_valid_r, state_r,
                                     phase_r, tag_r};
                    bms_pkg::ADDR_RESULT:
                        prdata_r <= {13'h0000, result_r.tag, last_count_r};
                    bms_pkg::ADDR_CONV_INFO:
                        prdata_r <= {res_eff > bms_pkg::RES_OUT_PWM_MAX ?
                                     bms_pkg::RES_OUT_PWM_MAX : res_eff,
                                     res_eff > bms_pkg::RES_OUT_ANALOG_MAX ?
                                     bms_pkg::RES_OUT_ANALOG_MAX : res_eff,
                                     conv_cycles};
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    // Sequencer
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state_r <= ST_PICK;
            in_start_r <= 1'b1;
            start_step_r <= '0;
            phase_r <= '0;
            br_cnt_r <= '0;
            conv_cnt_r <= '0;
            mux_r <= bms_pkg::MUX_AUTOZERO;
            tag_r <= bms_pkg::TAG_BRIDGE;
        end
        else
        begin
            unique case (state_r)
                ST_PICK:
                begin
                    if (run)
                    begin
                        mux_r <= pick_bridge ? bms_pkg::MUX_BRIDGE : pick_mux;
                        tag_r <= pick_bridge ? bms_pkg::TAG_BRIDGE : pick_tag;
                        conv_cnt_r <= conv_cycles;
                        state_r <= ST_CONV;
                        if (in_start_r)
                        begin
                            if (start_step_r == 2'h3 ||
                                (start_step_r == 2'h1 && !t1e))
                            begin
                                in_start_r <= 1'b0;
                            end
                            start_step_r <= start_step_r + 2'h1;
                        end
                        else if (pick_bridge)
                        begin
                            br_cnt_r <= br_cnt_r + 8'h01;
                        end
                        else
                        begin
                            br_cnt_r <= '0;
                            if (phase_r == 3'h2 && !t2e)
                            begin
                                phase_r <= 3'h5;
                            end
                            else if (phase_r == 3'h5)
                            begin
                                phase_r <= '0;
                            end
                            else
                            begin
                                phase_r <= phase_r + 3'h1;
                            end
                        end
                    end
                end
                ST_CONV:
                begin
                    conv_cnt_r <= conv_cnt_r - bms_pkg::CNT_W'(1);
                    if (conv_cnt_r == bms_pkg::CNT_W'(1))
                    begin
                        state_r <= ST_HAND;
                    end
                end
                ST_HAND:
                begin
                    if (i_res_ready)
                    begin
                        state_r <= ST_PICK;
                    end
                end
            endcase
        end
    end

    // Result handed to the calibration controller
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            res_valid_r <= 1'b0;
            result_r <= '0;
            last_count_r <= '0;
        end
        else if (state_r == ST_CONV && conv_cnt_r == bms_pkg::CNT_W'(1))
        begin
            res_valid_r <= 1'b1;
            result_r.count <= i_conv_count;
            result_r.tag <= tag_r;
            last_count_r <= i_conv_count;
        end
        else if (state_r == ST_HAND && i_res_ready)
        begin
            res_valid_r <= 1'b0;
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = 1'b1;
    assign o_pslverr = pslverr_r && i_psel && i_penable;
    assign o_mux_sel = mux_r;
    assign o_conv_active = (state_r == ST_CONV);
    assign o_conv_cfg = conv_cfg;
    assign o_zero_count = zero_count(res_eff,
                                     conv_cfg.range_shift_fraction);
    assign o_res_valid = res_valid_r;
    assign o_result = result_r;
endmodule : bms_sequencer

// ---- verification/bms_cal_model.sv ----
// Calibration controller and converter count source
`timescale 1ns/1ns
module bms_cal_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire bms_pkg::bms_mux_e i_mux_sel,
    input wire logic i_conv_active,
    input wire logic i_res_valid,
    input wire logic [3:0] i_slow,
    output logic [15:0] o_conv_count,
    output logic o_res_ready
);
    logic [3:0] wait_r;
    // Count marks the input; scrambled outside conversions
    always_ff @(posedge i_core_clk)
    begin
        if (i_conv_active)
            o_conv_count <= {13'h1500, i_mux_sel};
        else
            o_conv_count <= ~o_conv_count;
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || !i_res_valid || o_res_ready)
            wait_r <= 4'h0;
        else
            wait_r <= wait_r + 4'h1;
    end
    // Accepts each tagged count after i_slow cycles
    assign o_res_ready = i_res_valid && wait_r >= i_slow;
endmodule : bms_cal_model

// ---- verification/bms_checker.sv ----
// Assertions on the ports of the bridge measurement sequencer
`timescale 1ns/1ns
module bms_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_res_ready,
    input wire bms_pkg::bms_mux_e o_mux_sel,
    input wire logic o_conv_active,
    input wire bms_pkg::bms_conv_s o_conv_cfg,
    input wire logic [15:0] o_zero_count,
    input wire logic o_res_valid,
    input wire bms_pkg::bms_result_s o_result
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic [15:0] zero_exp;
    assign zero_exp = 16'((32'h1 << o_conv_cfg.resolution)
        >> ({1'b0, o_conv_cfg.range_shift_fraction} + 3'h1));
    sequence s_waiting;
        o_res_valid && !i_res_ready;
    endsequence
    sequence s_taken;
        o_res_valid && i_res_ready;
    endsequence
    chk_result_hold: assert property (s_waiting |=> o_res_valid
        && $stable(o_result)) else $error("result dropped or changed");
    chk_taken_clear: assert property (s_taken |=> !o_res_valid)
        else $error("result still valid after hand-over");
    chk_conv_valid: assert property ($fell(o_conv_active) |->
        o_res_valid) else $error("no result after conversion");
    chk_mux_steady: assert property (o_conv_active ##1 o_conv_active
        |-> $stable(o_mux_sel)) else $error("mux moved in conversion");
    chk_bridge_mux: assert property (o_res_valid &&
        o_result.tag == bms_pkg::TAG_BRIDGE |->
        o_mux_sel == bms_pkg::MUX_BRIDGE) else $error("bridge tag mux");
    chk_ref_forces: assert property (o_conv_cfg.converter_reference_select
        |-> o_conv_cfg.xzc_enable && o_conv_cfg.xzc_step == 6'sh0)
        else $error("reference mode zero shift");
    chk_res_range: assert property (o_conv_cfg.second_order ?
        o_conv_cfg.resolution >= 4'hb : (o_conv_cfg.resolution >= 4'h9
        && o_conv_cfg.resolution <= 4'he)) else $error("resolution range");
    chk_step_range: assert property (o_conv_cfg.xzc_step != -6'sh20)
        else $error("zero shift step out of range");
    chk_zero_count: assert property (o_zero_count == zero_exp)
        else $error("zero input count");
    chk_apb_error: assert property (i_psel && i_penable && i_paddr > 8'h10
        |-> o_pready && o_pslverr) else $error("unmapped access");
endmodule : bms_checker

// ---- verification/testbench.sv ----
// Self-checking bench for the bridge measurement sequencer
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, active, valid, ready, err;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] count, zero;
    logic [3:0] slow = 4'h0;
    bms_pkg::bms_mux_e mux, t1_mux, t2_mux;
    bms_pkg::bms_conv_s cfg;
    bms_pkg::bms_result_s res;
    int num_errors = 0, checks_done = 0;
    bms_pkg::bms_tag_e exp_q[$];
    bms_sequencer #(.CLK_PER_US(1)) dut_u (.i_core_clk(clk),
        .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_conv_count(count), .i_res_ready(ready), .o_mux_sel(mux),
        .o_conv_active(active), .o_conv_cfg(cfg), .o_zero_count(zero),
        .o_res_valid(valid), .o_result(res));
    bms_cal_model cal_u (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_mux_sel(mux), .i_conv_active(active), .i_res_valid(valid),
        .i_slow(slow), .o_conv_count(count), .o_res_ready(ready));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic test_done;
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            check(32'h0, 32'h1);
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    function automatic bms_pkg::bms_mux_e mux_of(bms_pkg::bms_tag_e t);
        case (t)
            bms_pkg::TAG_BRIDGE: return bms_pkg::MUX_BRIDGE;
            bms_pkg::TAG_TEMP1: return t1_mux;
            bms_pkg::TAG_TEMP2: return t2_mux;
            bms_pkg::TAG_COMMON_MODE: return bms_pkg::MUX_COMMON_MODE;
            default: return bms_pkg::MUX_AUTOZERO;
        endcase
    endfunction : mux_of
    // Configures a cycle after reset and follows the tagged results
    task automatic run_seq(input logic [31:0] cyc, input logic [31:0] cnv);
        int n;
        do_reset();
        apb(1'b1, bms_pkg::ADDR_CONV_CFG, cnv);
        apb(1'b1, bms_pkg::ADDR_CYCLE_CFG, cyc);
        foreach (exp_q[i])
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (!(valid === 1'b1 && ready === 1'b1) && n < 9000);
            if (n >= 9000)
            begin
                check(32'h0, 32'h1);
                test_done();
            end
            check(32'(res.tag), 32'(exp_q[i]));
            check(32'(mux), 32'(mux_of(exp_q[i])));
            check(32'(res.count), {16'h0, 13'h1500, mux_of(exp_q[i])});
        end
    endtask : run_seq
    task automatic seq_full;
        exp_q = {bms_pkg::TAG_BRIDGE, bms_pkg::TAG_BRIDGE_AZ,
            bms_pkg::TAG_TEMP1_AZ, bms_pkg::TAG_TEMP1};
        for (int k = 0; k < 2; k++)
            exp_q = {exp_q, bms_pkg::TAG_BRIDGE, bms_pkg::TAG_TEMP1_AZ,
                bms_pkg::TAG_BRIDGE, bms_pkg::TAG_TEMP1,
                bms_pkg::TAG_BRIDGE, bms_pkg::TAG_BRIDGE_AZ,
                bms_pkg::TAG_BRIDGE, bms_pkg::TAG_TEMP2_AZ,
                bms_pkg::TAG_BRIDGE, bms_pkg::TAG_TEMP2,
                bms_pkg::TAG_BRIDGE, bms_pkg::TAG_COMMON_MODE};
        t1_mux = bms_pkg::MUX_DIODE;
        t2_mux = bms_pkg::MUX_THERMISTOR;
        run_seq(32'h63, 32'h17);
    endtask : seq_full
    // Four bridge samples per group, second temperature off, slow taker
    task automatic seq_groups;
        bms_pkg::bms_tag_e slots[4];
        slots = '{bms_pkg::TAG_TEMP1_AZ, bms_pkg::TAG_TEMP1,
            bms_pkg::TAG_BRIDGE_AZ, bms_pkg::TAG_COMMON_MODE};
        exp_q = {bms_pkg::TAG_BRIDGE, bms_pkg::TAG_BRIDGE_AZ,
            bms_pkg::TAG_TEMP1_AZ, bms_pkg::TAG_TEMP1};
        foreach (slots[s])
        begin
            repeat (4) exp_q.push_back(bms_pkg::TAG_BRIDGE);
            exp_q.push_back(slots[s]);
        end
        t1_mux = bms_pkg::MUX_BRIDGE_RES;
        slow <= 4'h5;
        run_seq(32'h146, 32'h17);
        slow <= 4'h0;
    endtask : seq_groups
    // Reset values, converter configuration write mask, unmapped access and conversion figures
    task automatic regs;
        logic [31:0] tbl[5][2];
        do_reset();
        apb(1'b0, bms_pkg::ADDR_CYCLE_CFG, 32'h0);
        check(rd, 32'h42);
        apb(1'b0, bms_pkg::ADDR_CONV_CFG, 32'h0);
        check(rd, 32'h18);
        apb(1'b0, 8'h14, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        tbl = '{'{32'h12, 32'h9900_0200}, '{32'h1e, 32'hcb00_4000},
            '{32'h1b, 32'hcb00_0100}, '{32'h19, 32'hcb00_00b5},
            '{32'hffff_ffff, 32'hcb00_0200}};
        foreach (tbl[i])
        begin
            apb(1'b1, bms_pkg::ADDR_CONV_CFG, tbl[i][0]);
            apb(1'b0, bms_pkg::ADDR_CONV_INFO, 32'h0);
            check(rd, tbl[i][1]);
        end
        apb(1'b0, bms_pkg::ADDR_CONV_CFG, 32'h0);
        check(rd, 32'h7fff);
        check(32'(cfg.xzc_step), 32'h0);
        apb(1'b1, bms_pkg::ADDR_CONV_CFG, 32'h4118);
        check(32'(cfg.xzc_step), 32'hffff_ffe1);
        apb(1'b0, bms_pkg::ADDR_STATUS, 32'h0);
        check(32'(rd[11]), 32'h1);
    endtask : regs
    initial
    begin
        repeat (16) @(posedge clk);
        seq_full();
        seq_groups();
        regs();
        test_done();
    end
endmodule : testbench
bind bms_sequencer bms_checker chk_u (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_res_ready(i_res_ready), .o_mux_sel(o_mux_sel),
    .o_conv_active(o_conv_active), .o_conv_cfg(o_conv_cfg),
    .o_zero_count(o_zero_count), .o_res_valid(o_res_valid),
    .o_result(o_result));
